/* File: design/rcs_pkg.sv */
/*
 Constants for the reset control sequencer: register offsets, cause flag
 positions, boot vector addresses and release timing.
 Assumes a single 125 MHz clock and a simple strobe register port.
 // Function
 // - Six reset requests accepted: pin, power-on, droop, software, watchdog, regulator.
 // - Power-on resets core, all peripherals and the debug TAP controller.
 // - Reset pin resets core and peripherals; TAP only gets pin configuration reset.
 // - Droop, software system, watchdog, regulator resets spare the debug TAP.
 // - Software peripheral reset hits only selected peripherals, never core or TAP.
 // - Writing the system reset request bit starts a software system reset.
 // - Every reset sets the cause flag of its source.
 // - Cause flags are sticky across later reset sequences.
 // - A pin reset clears all other cause flags while setting its own.
 // - Pin and power-on resets select the main oscillator.
 // - Reset sequencing runs on the internal oscillator clock.
 // - Internal reset held until power-on detect goes inactive, then released.
 // - After release the core fetches stack pointer, program counter, first instruction.
 // - Power-on detect acts only on the initial power-up.
 // - Reset stays asserted while the pin is held, even after power-on ends.
 // - Identification and capability words are read-only.
*/
package rcs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_IDENT0 = 8'h00;
  localparam logic [7:0] OFS_IDENT1 = 8'h04;
  localparam logic [7:0] OFS_CAP0 = 8'h08;
  localparam logic [7:0] OFS_PERIPH_RST = 8'h20;
  localparam logic [7:0] OFS_CAUSE = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_CORE_IRC = 8'h2c;
  localparam int NUM_CAP = 5;
  localparam int NUM_PERIPH = 8;
  localparam int NUM_SRC = 6;
  // Cause flag positions
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_DROOP = 2;
  localparam int CAUSE_SW = 3;
  localparam int CAUSE_WDOG = 4;
  localparam int CAUSE_REG = 5;
  localparam logic [5:0] CAUSE_RESET = 6'h00;
  // System reset request bit in the core interrupt/reset control word
  localparam int SYSREQ_BIT = 2;
  // Boot vector addresses
  localparam logic [31:0] BOOT_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] BOOT_PC_ADDR = 32'h0000_0004;
  // Release stretch after last source goes quiet
  localparam int CLK_PERIOD_NS = 8;
  localparam int RELEASE_NS = 64;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RELEASE_CNT = 4'(RELEASE_CYC);
  // Arbitrary identification values
  localparam logic [31:0] IDENT0_VAL = 32'h0001_0000;
  localparam logic [31:0] IDENT1_VAL = 32'h0002_0000;
  localparam logic [31:0] CAP_VAL = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_HOLD, ST_STRETCH, ST_FETCH_SP, ST_FETCH_PC, ST_FETCH_INSN, ST_RUN
  } rcs_state_e;
endpackage

/* File: design/rcs_reset_sequencer.sv */
/*
 Reset control sequencer: merges six reset sources, drives core, TAP and
 peripheral resets, keeps sticky cause flags and runs the boot fetch.
 Assumes sys_clk is the internal oscillator and monitors are synchronous.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module rcs_reset_sequencer (
  input wire logic sys_clk, // Internal oscillator clock
  input wire logic rst, // Block power-up reset, sync
  input wire logic reset_pin_n, // External reset pin, low = reset
  input wire logic por_detect, // Power-on detect level
  input wire logic supply_droop_detect, // Brown-out monitor level
  input wire logic watchdog_reset_req, // Watchdog second time-out
  input wire logic core_regulator_fault, // Regulator out of regulation
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic boot_fetch_ack, // Memory answers a fetch
  input wire logic [31:0] boot_fetch_data, // Fetched word
  output logic boot_fetch_req, // Boot fetch request
  output logic [31:0] boot_fetch_addr, // Boot fetch address
  output logic [31:0] boot_sp, // Initial stack pointer
  output logic [31:0] boot_pc, // Initial program counter
  output logic [31:0] boot_insn, // First instruction
  output logic core_run, // Core may execute
  output logic core_reset, // Core reset, high active
  output logic tap_reset, // Full TAP controller reset
  output logic tap_pin_cfg_reset, // TAP pin configuration reset
  output logic [7:0] periph_reset, // Per-peripheral resets
  output logic use_main_osc, // Main oscillator select
  output logic irq // Unmasked cause flag pending
);
  rcs_pkg::rcs_state_e state;
  rcs_pkg::rcs_state_e next_state;
  logic pin_sync1;
  logic pin_sync2;
  logic por_armed;
  logic sw_sys_req;
  logic por_seen;
  logic pin_seen;
  logic [3:0] stretch_cnt;
  logic [5:0] cause;
  logic [5:0] next_cause;
  logic [5:0] irq_mask;
  logic [7:0] periph_ctrl;
  logic [7:0] periph_pulse;
  logic [31:0] next_rdata;

  // Source levels
  wire pin_active = ~pin_sync2;
  wire por_active = por_detect & por_armed;
  wire [5:0] src = {core_regulator_fault, watchdog_reset_req, sw_sys_req,
                    supply_droop_detect, por_active, pin_active};
  wire any_src = |src;
  wire in_reset = (state == rcs_pkg::ST_HOLD) || (state == rcs_pkg::ST_STRETCH);

  // Register decode
  wire wr_periph = reg_wr && (reg_addr == rcs_pkg::OFS_PERIPH_RST);
  wire wr_cause = reg_wr && (reg_addr == rcs_pkg::OFS_CAUSE);
  wire wr_mask = reg_wr && (reg_addr == rcs_pkg::OFS_IRQ_MASK);
  wire wr_irc = reg_wr && (reg_addr == rcs_pkg::OFS_CORE_IRC);
  wire sys_req_wr = wr_irc && reg_wdata[rcs_pkg::SYSREQ_BIT] && !in_reset;
  wire [5:0] cause_clr = wr_cause ? reg_wdata[5:0] : 6'h00;
  wire cap_hit = (reg_addr >= rcs_pkg::OFS_CAP0) &&
                 (reg_addr < rcs_pkg::OFS_CAP0 + 8'(4 * rcs_pkg::NUM_CAP)) &&
                 (reg_addr[1:0] == 2'h0);

  // Pin synchroniser; second stage is the only reader of the first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_sync1 <= 1'b1;
      pin_sync2 <= 1'b1;
    end else begin
      pin_sync1 <= reset_pin_n;
      pin_sync2 <= pin_sync1;
    end
  end

  // Power-on detect honoured only until the first release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_armed <= 1'b1;
    end else if (state == rcs_pkg::ST_FETCH_SP) begin
      por_armed <= 1'b0;
    end
  end

  // Software system request held one cycle as a source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_sys_req <= 1'b0;
    end else begin
      sw_sys_req <= sys_req_wr;
    end
  end

  // Which domains this reset sequence covers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_seen <= 1'b1;
      pin_seen <= 1'b0;
    end else if (!in_reset) begin
      por_seen <= por_active;
      pin_seen <= pin_active;
    end else begin
      por_seen <= por_seen | por_active;
      pin_seen <= pin_seen | pin_active;
    end
  end

  // Sequencer: hold while any source, stretch, then boot fetch
  always_comb begin
    next_state = state;
    unique case (state)
      rcs_pkg::ST_HOLD: begin
        if (!any_src) next_state = rcs_pkg::ST_STRETCH;
      end
      rcs_pkg::ST_STRETCH: begin
        if (any_src) next_state = rcs_pkg::ST_HOLD;
        else if (stretch_cnt == 4'h1) next_state = rcs_pkg::ST_FETCH_SP;
      end
      rcs_pkg::ST_FETCH_SP: begin
        if (boot_fetch_ack) next_state = rcs_pkg::ST_FETCH_PC;
      end
      rcs_pkg::ST_FETCH_PC: begin
        if (boot_fetch_ack) next_state = rcs_pkg::ST_FETCH_INSN;
      end
      rcs_pkg::ST_FETCH_INSN: begin
        if (boot_fetch_ack) next_state = rcs_pkg::ST_RUN;
      end
      rcs_pkg::ST_RUN: begin
        next_state = rcs_pkg::ST_RUN;
      end
    endcase
    if (any_src) next_state = rcs_pkg::ST_HOLD;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= rcs_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Release stretch counter
  always_ff @(posedge sys_clk) begin
    if (rst || state == rcs_pkg::ST_HOLD) begin
      stretch_cnt <= rcs_pkg::RELEASE_CNT;
    end else if (state == rcs_pkg::ST_STRETCH) begin
      stretch_cnt <= stretch_cnt - 4'h1;
    end
  end

  // Boot fetch: address and captured words from flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_fetch_addr <= rcs_pkg::BOOT_SP_ADDR;
      boot_sp <= 32'h0000_0000;
      boot_pc <= 32'h0000_0000;
      boot_insn <= 32'h0000_0000;
    end else if (in_reset) begin
      boot_fetch_addr <= rcs_pkg::BOOT_SP_ADDR;
    end else if (boot_fetch_ack && state == rcs_pkg::ST_FETCH_SP) begin
      boot_sp <= boot_fetch_data;
      boot_fetch_addr <= rcs_pkg::BOOT_PC_ADDR;
    end else if (boot_fetch_ack && state == rcs_pkg::ST_FETCH_PC) begin
      boot_pc <= boot_fetch_data;
      boot_fetch_addr <= boot_fetch_data; // First instruction at the vector
    end else if (boot_fetch_ack && state == rcs_pkg::ST_FETCH_INSN) begin
      boot_insn <= boot_fetch_data;
    end
  end

  // Cause flags: set wins over software clear; pin cause wipes the rest
  always_comb begin
    next_cause = cause & ~cause_clr;
    if (pin_active) next_cause = 6'h00;
    next_cause = next_cause | src;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cause <= rcs_pkg::CAUSE_RESET;
    end else begin
      cause <= next_cause;
    end
  end

  // Software-owned control; cleared only by power-on
  always_ff @(posedge sys_clk) begin
    if (rst || por_active) begin
      irq_mask <= 6'h00;
      periph_ctrl <= 8'h00;
    end else begin
      if (wr_mask) irq_mask <= reg_wdata[5:0];
      if (wr_periph) periph_ctrl <= reg_wdata[7:0];
    end
  end

  // Per-peripheral reset: bit set then cleared gives one pulse
  genvar gi;
  generate
    for (gi = 0; gi < rcs_pkg::NUM_PERIPH; gi++) begin : g_periph
      assign periph_pulse[gi] = periph_ctrl[gi] && wr_periph && !reg_wdata[gi];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          periph_reset[gi] <= 1'b1;
        end else begin
          periph_reset[gi] <= in_reset || any_src || periph_pulse[gi];
        end
      end
    end
  endgenerate

  // Read mux; identification words ignore writes
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (1'b1)
      reg_addr == rcs_pkg::OFS_IDENT0: next_rdata = rcs_pkg::IDENT0_VAL;
      reg_addr == rcs_pkg::OFS_IDENT1: next_rdata = rcs_pkg::IDENT1_VAL;
      cap_hit: next_rdata = rcs_pkg::CAP_VAL;
      reg_addr == rcs_pkg::OFS_PERIPH_RST: next_rdata = {24'h0, periph_ctrl};
      reg_addr == rcs_pkg::OFS_CAUSE: next_rdata = {26'h0, cause};
      reg_addr == rcs_pkg::OFS_IRQ_MASK: next_rdata = {26'h0, irq_mask};
      reg_addr == rcs_pkg::OFS_CORE_IRC: next_rdata = {29'h0, state};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Domain outputs
  assign core_reset = in_reset;
  assign tap_reset = in_reset && por_seen;
  assign tap_pin_cfg_reset = in_reset && (por_seen || pin_seen);
  assign use_main_osc = in_reset && (por_seen || pin_seen);
  assign boot_fetch_req = (state == rcs_pkg::ST_FETCH_SP) ||
                          (state == rcs_pkg::ST_FETCH_PC) ||
                          (state == rcs_pkg::ST_FETCH_INSN);
  assign core_run = (state == rcs_pkg::ST_RUN);
  assign irq = |(cause & irq_mask);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  pin_sync_a: assert property (pin_active == !$past(reset_pin_n, 2))
    else $error("pin synchroniser latency wrong");
  por_tap_a: assert property (por_active |=> tap_reset && core_reset)
    else $error("power-on did not reset TAP");
  pin_only_cfg_a: assert property ((pin_active && !por_seen && !por_active)
    |=> core_reset && tap_pin_cfg_reset && !tap_reset)
    else $error("pin reset touched TAP state");
  droop_spare_a: assert property ((supply_droop_detect && !por_seen && !por_active)
    |=> core_reset && !tap_reset && &periph_reset)
    else $error("droop reset domains wrong");
  periph_only_a: assert property ((periph_pulse[0] && core_run && !any_src)
    |=> periph_reset[0] && !core_reset && !tap_reset)
    else $error("peripheral reset spread");
  sys_req_a: assert property ((sys_req_wr && !any_src)
    |-> ##2 core_reset && cause[rcs_pkg::CAUSE_SW])
    else $error("system request ignored");
  wdog_cause_a: assert property (watchdog_reset_req
    |=> cause[rcs_pkg::CAUSE_WDOG])
    else $error("watchdog cause missing");
  cause_sticky_a: assert property ((cause[rcs_pkg::CAUSE_DROOP] && !wr_cause && !pin_active)
    |=> cause[rcs_pkg::CAUSE_DROOP])
    else $error("cause flag lost");
  pin_clears_a: assert property ((pin_active && !(|src[5:1]))
    |=> cause == 6'h01)
    else $error("pin reset left other flags");
  pin_hold_a: assert property (pin_active
    |=> core_reset [*2])
    else $error("pin did not extend reset");
  release_a: assert property ((state == rcs_pkg::ST_HOLD && !any_src) ##1 (!any_src) [*8]
    |=> !core_reset && boot_fetch_req)
    else $error("release timing wrong");
  fetch_order_a: assert property ((state == rcs_pkg::ST_FETCH_SP && boot_fetch_ack && !any_src)
    |=> state == rcs_pkg::ST_FETCH_PC && boot_fetch_addr == rcs_pkg::BOOT_PC_ADDR)
    else $error("boot fetch order wrong");
  ident_ro_a: assert property ((reg_rd && reg_addr == rcs_pkg::OFS_IDENT0)
    |=> reg_rdata == rcs_pkg::IDENT0_VAL)
    else $error("ident word wrong");

  // Source merging: a droop, watchdog or regulator request takes the core down next cycle
  src_merge_a: assert property ((supply_droop_detect || watchdog_reset_req ||
    core_regulator_fault) |=> core_reset)
    else $error("internal source ignored");

  core_gated_a: assert property (any_src
    |=> core_reset && !core_run && !boot_fetch_req)
    else $error("core not held by source");

  periph_all_a: assert property (any_src |=> &periph_reset)
    else $error("peripherals not reset");

  tap_subset_a: assert property (tap_reset |-> tap_pin_cfg_reset && core_reset)
    else $error("TAP reset outside core reset");

  // Peripheral resets stay quiet in run unless software asks
  periph_quiet_a: assert property ((core_run && !any_src && !periph_pulse[1])
    |=> !periph_reset[1])
    else $error("stray peripheral reset");

  // A request written during reset must not restart the sequence
  sw_blocked_a: assert property ((wr_irc && reg_wdata[rcs_pkg::SYSREQ_BIT] && in_reset)
    |=> !sw_sys_req)
    else $error("request taken in reset");

  // Each source leaves its own cause flag behind
  sw_cause_a: assert property (sw_sys_req |=> cause[rcs_pkg::CAUSE_SW])
    else $error("software cause missing");

  droop_cause_a: assert property (supply_droop_detect |=> cause[rcs_pkg::CAUSE_DROOP])
    else $error("droop cause missing");

  reg_cause_a: assert property (core_regulator_fault |=> cause[rcs_pkg::CAUSE_REG])
    else $error("regulator cause missing");

  por_cause_a: assert property (por_active |=> cause[rcs_pkg::CAUSE_POR])
    else $error("power-on cause missing");

  pin_cause_a: assert property (pin_active |=> cause[rcs_pkg::CAUSE_PIN])
    else $error("pin cause missing");

  cause_keep_a: assert property ((cause[rcs_pkg::CAUSE_WDOG] && !wr_cause && !pin_active)
    |=> cause[rcs_pkg::CAUSE_WDOG])
    else $error("watchdog flag lost");

  // Write-one clear works when the source is quiet
  w1c_a: assert property ((wr_cause && reg_wdata[rcs_pkg::CAUSE_DROOP] && !supply_droop_detect
    && !pin_active) |=> !cause[rcs_pkg::CAUSE_DROOP])
    else $error("cause flag not cleared");

  // Oscillator select follows pin and power-on
  osc_sel_a: assert property ((por_active || pin_active) |=> use_main_osc)
    else $error("main oscillator not selected");

  // Power-on honoured once; sequencer holds while sources stand
  por_disarm_a: assert property ((state == rcs_pkg::ST_FETCH_SP) |=> !por_active)
    else $error("power-on still armed");

  hold_stay_a: assert property ((state == rcs_pkg::ST_HOLD && any_src)
    |=> state == rcs_pkg::ST_HOLD)
    else $error("left hold with source");

  // Boot fetch walk: stack pointer, vector, instruction, run
  fetch_sp_a: assert property ((state == rcs_pkg::ST_STRETCH && stretch_cnt == 4'h1 && !any_src)
    |=> boot_fetch_req && boot_fetch_addr == rcs_pkg::BOOT_SP_ADDR)
    else $error("stack pointer fetch wrong");

  fetch_insn_a: assert property ((state == rcs_pkg::ST_FETCH_PC && boot_fetch_ack && !any_src)
    |=> state == rcs_pkg::ST_FETCH_INSN && boot_fetch_addr == $past(boot_fetch_data))
    else $error("instruction fetch address wrong");

  run_after_a: assert property ((state == rcs_pkg::ST_FETCH_INSN && boot_fetch_ack && !any_src)
    |=> core_run && !core_reset)
    else $error("core did not start");

  run_stays_a: assert property ((core_run && !any_src) |=> core_run)
    else $error("core stopped without source");

  // Read port: data only after a read strobe
  rdata_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without strobe");

  cap_ro_a: assert property ((reg_rd && cap_hit) |=> reg_rdata == rcs_pkg::CAP_VAL)
    else $error("capability word wrong");
endmodule
`default_nettype wire

/* File: testbench/rcs_boot_memory.sv */
/*
 Boot memory model answering the core's initial vector fetches.
 Assumes the sequencer holds req and addr until it samples ack high.
*/
`timescale 1ns/1ns
`default_nettype none
module rcs_boot_memory (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Sync reset
  input wire logic slow, // High adds wait cycles before ack
  input wire logic boot_fetch_req, // Fetch request
  input wire logic [31:0] boot_fetch_addr, // Fetch address
  output logic boot_fetch_ack, // One-cycle answer
  output logic [31:0] boot_fetch_data // Word, valid with ack only
);
  logic [1:0] wait_cnt;
  logic [31:0] word;
  // Stack pointer, start address, then the instruction found there
  assign word = (boot_fetch_addr == 32'h0) ? 32'h2000_0400 :
                (boot_fetch_addr == 32'h4) ? 32'h0000_0100 : 32'hbf00_bf00;
  // Data toggles outside ack so stale words never look valid
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_fetch_ack <= 1'b0;
      wait_cnt <= 2'h0;
      boot_fetch_data <= 32'h0;
    end else if (boot_fetch_ack) begin
      boot_fetch_ack <= 1'b0;
      wait_cnt <= 2'h0;
      boot_fetch_data <= ~boot_fetch_data;
    end else if (boot_fetch_req && (!slow || wait_cnt == 2'h3)) begin
      boot_fetch_ack <= 1'b1;
      boot_fetch_data <= word;
    end else begin
      wait_cnt <= boot_fetch_req ? wait_cnt + 2'h1 : 2'h0;
      boot_fetch_data <= ~boot_fetch_data;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/reset_control_sequencer_test.sv */
/*
 Self-checking bench for the reset sequencer: sources, cause flags, boot.
 Assumes rcs_boot_memory on the boot link and a register strobe port.
*/
`timescale 1ns/1ns
`default_nettype none
module reset_control_sequencer_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic por = 1'b1;
  logic droop = 1'b0;
  logic wdog = 1'b0;
  logic regf = 1'b0;
  logic slow = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, f_addr, f_data, boot_sp, boot_pc, boot_insn, rdat;
  logic f_req, f_ack, core_run, core_reset, tap_reset, tap_cfg, osc, irq;
  logic [7:0] periph_reset;
  logic [5:0] exp_cause;
  int miscompares = 0;
  int checks_done = 0;

  always #4 sys_clk = ~sys_clk;

  rcs_reset_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .por_detect(por), .supply_droop_detect(droop), .watchdog_reset_req(wdog),
    .core_regulator_fault(regf), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_fetch_ack(f_ack),
    .boot_fetch_data(f_data), .boot_fetch_req(f_req), .boot_fetch_addr(f_addr),
    .boot_sp(boot_sp), .boot_pc(boot_pc), .boot_insn(boot_insn), .core_run(core_run),
    .core_reset(core_reset), .tap_reset(tap_reset), .tap_pin_cfg_reset(tap_cfg),
    .periph_reset(periph_reset), .use_main_osc(osc), .irq(irq));
  rcs_boot_memory mem (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .boot_fetch_req(f_req), .boot_fetch_addr(f_addr), .boot_fetch_ack(f_ack),
    .boot_fetch_data(f_data));

  // One comparison, counted; mismatch reported at once
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Bounded wait for execution, then the fetched vectors
  task automatic wait_run;
    int n;
    n = 0;
    while (core_run !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("core_run", core_run, 32'h1);
    chk("boot_sp", boot_sp, 32'h2000_0400);
    chk("boot_pc", boot_pc, 32'h0000_0100);
    chk("boot_insn", boot_insn, 32'hbf00_bf00);
    rd(rcs_pkg::OFS_CAUSE, rdat);
    chk("cause", rdat, {26'h0, exp_cause});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 chk("por core_reset", core_reset, 32'h1);
    chk("por tap", {tap_reset, tap_cfg, osc, periph_reset}, 32'h7ff);
    por <= 1'b0;
    exp_cause = 6'h1 << rcs_pkg::CAUSE_POR;
    wait_run;
    $display("power-on test done");
    // Watchdog, droop, regulator and software requests, prompt and slow memory
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      slow <= i[0];
      if (i == 3) begin
        wr(rcs_pkg::OFS_CORE_IRC, 32'h1 << rcs_pkg::SYSREQ_BIT);
        exp_cause[rcs_pkg::CAUSE_SW] = 1'b1;
      end else begin
        wdog <= (i == 0);
        droop <= (i == 1);
        regf <= (i == 2);
        @(posedge sys_clk);
        {wdog, droop, regf} <= 3'h0;
        exp_cause[i == 0 ? rcs_pkg::CAUSE_WDOG : i == 1 ? rcs_pkg::CAUSE_DROOP
                  : rcs_pkg::CAUSE_REG] = 1'b1;
      end
      @(posedge sys_clk);
      #1 chk("src core_reset", core_reset, 32'h1);
      chk("src tap", {tap_reset, tap_cfg, osc, periph_reset}, 32'h0ff);
      wait_run;
    end
    $display("internal sources test done");
    rd(rcs_pkg::OFS_CORE_IRC, rdat);
    chk("state", rdat, 32'h5);
    wr(rcs_pkg::OFS_IRQ_MASK, 32'h1 << rcs_pkg::CAUSE_WDOG);
    #1 chk("irq set", irq, 32'h1);
    wr(rcs_pkg::OFS_CAUSE, 32'h1 << rcs_pkg::CAUSE_WDOG);
    #1 chk("irq clear", irq, 32'h0);
    rd(rcs_pkg::OFS_CAUSE, rdat);
    exp_cause[rcs_pkg::CAUSE_WDOG] = 1'b0;
    chk("w1c cause", rdat, {26'h0, exp_cause});
    $display("interrupt test done");
    wr(rcs_pkg::OFS_PERIPH_RST, 32'h05);
    wr(rcs_pkg::OFS_PERIPH_RST, 32'h00);
    #1 chk("periph sel", {core_reset, tap_reset, tap_cfg, periph_reset}, 32'h05);
    rd(rcs_pkg::OFS_IDENT0, rdat);
    chk("ident0", rdat, rcs_pkg::IDENT0_VAL);
    wr(rcs_pkg::OFS_IDENT1, 32'hffff_ffff);
    rd(rcs_pkg::OFS_IDENT1, rdat);
    chk("ident1 ro", rdat, rcs_pkg::IDENT1_VAL);
    rd(rcs_pkg::OFS_CAP0, rdat);
    chk("cap0", rdat, rcs_pkg::CAP_VAL);
    rd(8'h40, rdat);
    chk("unmapped", rdat, 32'h0);
    $display("register test done");
    // Pin held well past the stretch, then released
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 chk("pin hold", core_reset, 32'h1);
    chk("pin tap", {tap_reset, tap_cfg, osc, periph_reset}, 32'h3ff);
    reset_pin_n <= 1'b1;
    exp_cause = 6'h1 << rcs_pkg::CAUSE_PIN;
    wait_run;
    $display("pin test done");
    @(posedge sys_clk);
    por <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk("por again", {core_run, core_reset}, 32'h2);
    por <= 1'b0;
    rd(rcs_pkg::OFS_CAUSE, rdat);
    chk("por again cause", rdat, {26'h0, exp_cause});
    $display("power-on repeat test done");
    end_of_test;
  end
endmodule
`default_nettype wire
